// ==== inc/tcc_pkg.sv ====
// package for the timer capture, control and status block
package tcc_pkg;
    // register byte addresses
    localparam logic [7:0] TCC_ADDR_CTRL = 8'h12;
    localparam logic [7:0] TCC_ADDR_FLAGS = 8'h13;
    localparam logic [7:0] TCC_ADDR_CAP_HI = 8'h14;
    localparam logic [7:0] TCC_ADDR_CAP_LO = 8'h15;
    localparam logic [7:0] TCC_ADDR_CMP_HI = 8'h16;
    localparam logic [7:0] TCC_ADDR_CMP_LO = 8'h17;
    localparam logic [7:0] TCC_ADDR_CNT_HI = 8'h18;
    localparam logic [7:0] TCC_ADDR_CNT_LO = 8'h19;
    localparam logic [7:0] TCC_ADDR_ALT_HI = 8'h1a;
    localparam logic [7:0] TCC_ADDR_ALT_LO = 8'h1b;
    // control field positions
    localparam int TCC_BIT_CAP_IE = 7;
    localparam int TCC_BIT_MATCH_IE = 6;
    localparam int TCC_BIT_WRAP_IE = 5;
    localparam int TCC_BIT_EDGE = 1;
    localparam int TCC_BIT_LEVEL = 0;
    // flag field positions
    localparam int TCC_BIT_CAP_F = 7;
    localparam int TCC_BIT_MATCH_F = 6;
    localparam int TCC_BIT_WRAP_F = 5;
    // reset values
    localparam logic [15:0] TCC_COUNT_RST = 16'hfffc;
    localparam logic [1:0] TCC_PRESCALE_RST = 2'h0;
    // prescaler: counter steps when prescale reaches this value (every four clocks)
    localparam logic [1:0] TCC_PRESCALE_LAST = 2'h3;
    // prescaler phase in which compare is evaluated
    localparam logic [1:0] TCC_CMP_PHASE = 2'h0;
    // two-step access sequence state
    typedef enum logic [0:0] {
        TCC_SEQ_IDLE = 1'b0,
        TCC_SEQ_HELD = 1'b1
    } tcc_seq_t;
endpackage

// ==== rtl/tcc_timer.sv ====
// timer capture, control and status logic with free-running counter
//
// What this block does
// - capture count on selected edge of pin
// - captured value is one above prior count
// - edges overwrite capture unless held, flag regardless
// - high byte read blocks capture until low
// - low byte read alone never blocks capture
// - a transfer in the cycle of a high byte read still loads capture
// - reset keeps capture register contents
// - control byte layout, bits four-two zero
// - enables gate interrupt, cleared by reset
// - reset keeps capture edge select
// - match loads level bit into pin register
// - compare pin low in reset until match
// - status top bits are read-only flags
// - capture flag set, cleared by status-then-low
// - match flag set, cleared by status-then-low
// - wrap flag set, cleared by status-then-count-low
// - reset keeps all three flags
// - mirror reads same count, never clears wrap
// - status access arms only flags then set
// - wait keeps running, stop freezes state
// - counter advances every four clocks
// - counter resets to fffc, read-only
`timescale 1ns/1ps
module tcc_timer
    import tcc_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic stop_mode,
    input wire logic [7:0] bus_addr,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic capture_in,
    output logic compare_out_pin,
    output logic timer_irq
);

    // run only when enabled and not in stop mode; wait mode keeps running
    logic run;
    assign run = clk_en && !stop_mode;

    // bus access decode helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    // any bus access strobe
    logic acc;
    assign acc = bus_rd || bus_wr;

    // prescaler and free-running counter
    logic [1:0] pre_q;
    logic [15:0] count_q;
    logic step;
    assign step = (pre_q == TCC_PRESCALE_LAST);

    // divide by four, counter preset on reset
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pre_q <= TCC_PRESCALE_RST;
            count_q <= TCC_COUNT_RST;
        end else if (run) begin
            // prescaler rolls every four cycles; counter steps on its last phase
            pre_q <= pre_q + 2'h1;
            if (step) begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

    // counter low-byte latch for coherent two-byte reads
    logic [7:0] cnt_buf_q;
    logic cnt_held_q;
    // latch low byte on high byte read, release on low byte read
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_buf_q <= 8'h00;
            cnt_held_q <= 1'b0;
        end else if (run && bus_rd) begin
            if (hit(bus_addr, TCC_ADDR_CNT_HI) || hit(bus_addr, TCC_ADDR_ALT_HI)) begin
                // repeated high reads keep the first buffered byte
                if (!cnt_held_q) begin
                    cnt_buf_q <= count_q[7:0];
                end
                cnt_held_q <= 1'b1;
            end else if (hit(bus_addr, TCC_ADDR_CNT_LO) || hit(bus_addr, TCC_ADDR_ALT_LO)) begin
                cnt_held_q <= 1'b0;
            end
        end
    end

    // control register: enables reset, edge select kept
    logic cap_ie_q, match_ie_q, wrap_ie_q, level_q;
    logic edge_sel_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cap_ie_q <= 1'b0;
            match_ie_q <= 1'b0;
            wrap_ie_q <= 1'b0;
            level_q <= 1'b0;
        end else if (run && bus_wr && hit(bus_addr, TCC_ADDR_CTRL)) begin
            cap_ie_q <= bus_wdata[TCC_BIT_CAP_IE];
            match_ie_q <= bus_wdata[TCC_BIT_MATCH_IE];
            wrap_ie_q <= bus_wdata[TCC_BIT_WRAP_IE];
            level_q <= bus_wdata[TCC_BIT_LEVEL];
        end
    end

    // edge select has no reset term
    always_ff @(posedge mclk) begin
        if (run && bus_wr && hit(bus_addr, TCC_ADDR_CTRL)) begin
            edge_sel_q <= bus_wdata[TCC_BIT_EDGE];
        end
    end

    // compare register, not touched by reset; high write inhibits compare
    logic [15:0] cmp_q;
    always_ff @(posedge mclk) begin
        if (run && bus_wr && hit(bus_addr, TCC_ADDR_CMP_HI)) begin
            cmp_q[15:8] <= bus_wdata;
        end
        if (run && bus_wr && hit(bus_addr, TCC_ADDR_CMP_LO)) begin
            cmp_q[7:0] <= bus_wdata;
        end
    end

    tcc_seq_t cmp_seq_q;
    // compare inhibit after high byte write until low byte write
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cmp_seq_q <= TCC_SEQ_IDLE;
        end else if (run && bus_wr) begin
            if (hit(bus_addr, TCC_ADDR_CMP_HI)) begin
                cmp_seq_q <= TCC_SEQ_HELD;
            end else if (hit(bus_addr, TCC_ADDR_CMP_LO)) begin
                cmp_seq_q <= TCC_SEQ_IDLE;
            end
        end
    end

    // compare once per prescaler period
    logic match_ev;
    assign match_ev = run && pre_q == TCC_CMP_PHASE && cmp_seq_q == TCC_SEQ_IDLE
                      && count_q == cmp_q;

    // output level register drives the pin, cleared by reset
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            compare_out_pin <= 1'b0;
        end else if (match_ev) begin
            compare_out_pin <= level_q;
        end
    end

    // capture edge detector; pin sampled synchronously
    logic cap_prev_q;
    always_ff @(posedge mclk) begin
        if (run) begin
            cap_prev_q <= capture_in;
        end
    end

    // qualifying edge of the selected polarity
    logic edge_ev;
    assign edge_ev = run && (edge_sel_q ? (capture_in && !cap_prev_q)
                                        : (!capture_in && cap_prev_q));

    // capture high read holds transfers until low read
    tcc_seq_t cap_seq_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cap_seq_q <= TCC_SEQ_IDLE;
        end else if (run && bus_rd) begin
            if (hit(bus_addr, TCC_ADDR_CAP_HI)) begin
                cap_seq_q <= TCC_SEQ_HELD;
            end else if (hit(bus_addr, TCC_ADDR_CAP_LO)) begin
                cap_seq_q <= TCC_SEQ_IDLE;
            end
        end
    end

    // capture register, not reset; one above the prior count
    logic [15:0] cap_q;
    logic cap_load;
    assign cap_load = edge_ev && cap_seq_q == TCC_SEQ_IDLE;
    always_ff @(posedge mclk) begin
        if (cap_load) begin
            cap_q <= count_q + 16'h0001;
        end
    end

    // flags: no reset; armed by status access while set
    logic cap_f_q, match_f_q, wrap_f_q;
    logic cap_arm_q, match_arm_q, wrap_arm_q;
    logic wrap_ev;
    assign wrap_ev = run && step && count_q == 16'hffff;

    // access decodes for the two-step flag clears
    logic st_acc, cap_lo_acc, cmp_lo_acc, cnt_lo_rd;
    assign st_acc = run && acc && hit(bus_addr, TCC_ADDR_FLAGS);
    assign cap_lo_acc = run && acc && hit(bus_addr, TCC_ADDR_CAP_LO);
    assign cmp_lo_acc = run && acc && hit(bus_addr, TCC_ADDR_CMP_LO);
    assign cnt_lo_rd = run && bus_rd && hit(bus_addr, TCC_ADDR_CNT_LO);

    // flag set wins over clear; arms reflect flag at status access
    // no reset branch, so the flags ride through reset
    always_ff @(posedge mclk) begin
        if (edge_ev) begin
            cap_f_q <= 1'b1;
        end else if (cap_lo_acc && cap_arm_q) begin
            cap_f_q <= 1'b0;
        end
        if (match_ev) begin
            match_f_q <= 1'b1;
        end else if (cmp_lo_acc && match_arm_q) begin
            match_f_q <= 1'b0;
        end
        if (wrap_ev) begin
            wrap_f_q <= 1'b1;
        end else if (cnt_lo_rd && wrap_arm_q) begin
            wrap_f_q <= 1'b0;
        end
    end

    // arm latches: reset clears them, flags themselves kept
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cap_arm_q <= 1'b0;
            match_arm_q <= 1'b0;
            wrap_arm_q <= 1'b0;
        end else if (st_acc) begin
            cap_arm_q <= cap_f_q;
            match_arm_q <= match_f_q;
            wrap_arm_q <= wrap_f_q;
        end else begin
            // the associated access ends an armed sequence
            if (cap_lo_acc) begin
                cap_arm_q <= 1'b0;
            end
            if (cmp_lo_acc) begin
                match_arm_q <= 1'b0;
            end
            if (cnt_lo_rd) begin
                wrap_arm_q <= 1'b0;
            end
        end
    end

    // single interrupt from any enabled flag
    assign timer_irq = (cap_f_q && cap_ie_q) || (match_f_q && match_ie_q)
                       || (wrap_f_q && wrap_ie_q);

    // read data mux, registered; a capture in the cycle of a high byte read still loads
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rdata <= 8'h00;
        end else if (run && bus_rd) begin
            if (hit(bus_addr, TCC_ADDR_CTRL)) begin
                bus_rdata <= {cap_ie_q, match_ie_q, wrap_ie_q, 3'h0, edge_sel_q, level_q};
            end else if (hit(bus_addr, TCC_ADDR_FLAGS)) begin
                bus_rdata <= {cap_f_q, match_f_q, wrap_f_q, 5'h00};
            end else if (hit(bus_addr, TCC_ADDR_CAP_HI)) begin
                bus_rdata <= cap_q[15:8];
            end else if (hit(bus_addr, TCC_ADDR_CAP_LO)) begin
                bus_rdata <= cap_q[7:0];
            end else if (hit(bus_addr, TCC_ADDR_CMP_HI)) begin
                bus_rdata <= cmp_q[15:8];
            end else if (hit(bus_addr, TCC_ADDR_CMP_LO)) begin
                bus_rdata <= cmp_q[7:0];
            end else if (hit(bus_addr, TCC_ADDR_CNT_HI) || hit(bus_addr, TCC_ADDR_ALT_HI)) begin
                bus_rdata <= count_q[15:8];
            end else if (hit(bus_addr, TCC_ADDR_CNT_LO) || hit(bus_addr, TCC_ADDR_ALT_LO)) begin
                bus_rdata <= cnt_held_q ? cnt_buf_q : count_q[7:0];
            end else begin
                bus_rdata <= 8'h00;
            end
        end
    end

    // assertions
    // every property is disabled while reset is held
    property p_capture_value;
        @(posedge mclk) disable iff (!arst_n)
        cap_load |=> cap_q == $past(count_q) + 16'h0001;
    endproperty
    a_capture_value: assert property (p_capture_value) else $error("bad capture value");

    property p_capture_block;
        @(posedge mclk) disable iff (!arst_n)
        (cap_seq_q == TCC_SEQ_HELD) |=> $stable(cap_q);
    endproperty
    a_capture_block: assert property (p_capture_block) else $error("capture while held");

    property p_capture_flag_set;
        @(posedge mclk) disable iff (!arst_n)
        edge_ev |=> cap_f_q;
    endproperty
    a_capture_flag_set: assert property (p_capture_flag_set) else $error("capture flag unset");

    property p_wrap_set;
        @(posedge mclk) disable iff (!arst_n)
        wrap_ev |=> wrap_f_q && count_q == 16'h0000;
    endproperty
    a_wrap_set: assert property (p_wrap_set) else $error("wrap flag not set");

    property p_step_four;
        @(posedge mclk) disable iff (!arst_n)
        (run && step) ##1 (run [*4]) |-> count_q == $past(count_q, 1);
    endproperty
    a_step_four: assert property (p_step_four) else $error("counter step spacing");

    property p_pin_level;
        @(posedge mclk) disable iff (!arst_n)
        match_ev |=> compare_out_pin == $past(level_q);
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("pin level wrong");

    property p_irq;
        @(posedge mclk) disable iff (!arst_n)
        (wrap_f_q && wrap_ie_q) |-> timer_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_mirror_keeps;
        @(posedge mclk) disable iff (!arst_n)
        (wrap_f_q && run && bus_rd && hit(bus_addr, TCC_ADDR_ALT_LO)) |=> wrap_f_q;
    endproperty
    a_mirror_keeps: assert property (p_mirror_keeps) else $error("mirror cleared wrap");

    property p_stop_freeze;
        @(posedge mclk) disable iff (!arst_n)
        (clk_en && stop_mode) |=> $stable(count_q);
    endproperty
    a_stop_freeze: assert property (p_stop_freeze) else $error("counter ran in stop");

    property p_ctrl_zero;
        @(posedge mclk) disable iff (!arst_n)
        (run && bus_rd && hit(bus_addr, TCC_ADDR_CTRL)) |=> bus_rdata[4:2] == 3'h0;
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("control spare bits set");

    property p_low_read_free;
        @(posedge mclk) disable iff (!arst_n)
        (run && bus_rd && hit(bus_addr, TCC_ADDR_CAP_LO)) |=> cap_seq_q == TCC_SEQ_IDLE;
    endproperty
    a_low_read_free: assert property (p_low_read_free) else $error("low read blocked");

    property p_arm_only_set;
        @(posedge mclk) disable iff (!arst_n)
        (st_acc && !wrap_f_q) |=> !wrap_arm_q;
    endproperty
    a_arm_only_set: assert property (p_arm_only_set) else $error("clear flag armed");

    property p_pin_hold;
        @(posedge mclk) disable iff (!arst_n)
        !match_ev |=> $stable(compare_out_pin);
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin moved without match");

    // main scenarios reached
    c_cap_held: cover property (@(posedge mclk) disable iff (!arst_n)
        cap_seq_q == TCC_SEQ_HELD && edge_ev);
    c_capture: cover property (@(posedge mclk) disable iff (!arst_n) cap_load);
    c_wrap: cover property (@(posedge mclk) disable iff (!arst_n) wrap_ev);
    c_match: cover property (@(posedge mclk) disable iff (!arst_n) match_ev);
    c_cap_clear: cover property (@(posedge mclk) disable iff (!arst_n)
        cap_f_q ##1 !cap_f_q);

endmodule

// ==== tb/tb_tcc_timer.sv ====
// self-checking testbench for the timer capture, control and status block
`timescale 1ns/1ps
module tb_tcc_timer;
    import tcc_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1; // clock enable, dropped once to check the freeze
    logic stop_mode = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic bus_rd = 1'b0;
    logic bus_wr = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic [7:0] bus_rdata;
    logic capture_in;
    logic compare_out_pin;
    logic timer_irq;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [7:0] d, lo0;
    logic [15:0] c0, c1, cap;

    // 40 mhz clock
    initial begin
        forever #12.5 mclk = ~mclk;
    end

    tcc_timer dut (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en), .stop_mode(stop_mode),
        .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .capture_in(capture_in), .compare_out_pin(compare_out_pin),
        .timer_irq(timer_irq));

    tcc_pin_model pin (.mclk(mclk), .capture_in(capture_in));

    // compare one byte, count and report
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one read strobe, data taken the cycle after
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        #1 bus_addr = a;
        bus_rd = 1'b1;
        @(posedge mclk);
        #1 bus_rd = 1'b0;
        v = bus_rdata;
    endtask

    // one write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        #1 bus_addr = a;
        bus_wdata = v;
        bus_wr = 1'b1;
        @(posedge mclk);
        #1 bus_wr = 1'b0;
    endtask

    // high byte first, then low byte
    task automatic rd16(input logic [7:0] ah, input logic [7:0] al, output logic [15:0] v);
        logic [7:0] h, l;
        rd(ah, h);
        rd(al, l);
        v = {h, l};
    endtask

    // verdict and end of run
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            final_report;
        end
    end

    // main sequence
    initial begin
        repeat (8) @(posedge mclk);
        #1 arst_n = 1'b1;
        rd16(TCC_ADDR_CNT_HI, TCC_ADDR_CNT_LO, c0);
        chk(c0[15:8], 8'hff);
        chk(c0[7:0], 8'hfc);
        chk({7'h0, compare_out_pin}, 8'h00);
        // edge select has no reset value, so bit 1 is left out here
        rd(TCC_ADDR_CTRL, d);
        chk(d & 8'hfd, 8'h00);
        wr(TCC_ADDR_CTRL, 8'hff);
        rd(TCC_ADDR_CTRL, d);
        chk(d, 8'he3);
        wr(TCC_ADDR_CTRL, 8'h20);
        repeat (20) @(posedge mclk);
        #1 chk({7'h0, timer_irq}, 8'h01);
        rd(TCC_ADDR_FLAGS, d);
        chk(d & 8'h20, 8'h20);
        rd(TCC_ADDR_ALT_LO, d);
        rd(TCC_ADDR_FLAGS, d);
        chk(d & 8'h20, 8'h20);
        rd(TCC_ADDR_CNT_LO, d);
        rd(TCC_ADDR_FLAGS, d);
        chk(d & 8'h20, 8'h00);
        chk({7'h0, timer_irq}, 8'h00);
        // compare match drives the level bit to the pin and raises the interrupt
        wr(TCC_ADDR_CTRL, 8'h43);
        rd16(TCC_ADDR_CNT_HI, TCC_ADDR_CNT_LO, c0);
        c1 = c0 + 16'h000c;
        wr(TCC_ADDR_CMP_HI, c1[15:8]);
        wr(TCC_ADDR_CMP_LO, c1[7:0]);
        repeat (60) @(posedge mclk);
        #1 chk({7'h0, compare_out_pin}, 8'h01);
        chk({7'h0, timer_irq}, 8'h01);
        rd(TCC_ADDR_FLAGS, d);
        chk(d & 8'h40, 8'h40);
        wr(TCC_ADDR_CMP_LO, c1[7:0]);
        rd(TCC_ADDR_FLAGS, d);
        chk(d & 8'h40, 8'h00);
        chk({7'h0, timer_irq}, 8'h00);
        // rising edge capture, value one above prior count
        rd16(TCC_ADDR_ALT_HI, TCC_ADDR_ALT_LO, c0);
        pin.drive(1'b1);
        repeat (4) @(posedge mclk);
        rd(TCC_ADDR_FLAGS, d);
        chk(d & 8'h80, 8'h80);
        rd16(TCC_ADDR_CAP_HI, TCC_ADDR_CAP_LO, cap);
        c1 = cap - c0;
        chk((c1 >= 16'h1 && c1 <= 16'h3) ? 8'h01 : 8'h00, 8'h01);
        // falling edge ignored while rising selected
        pin.drive(1'b0);
        repeat (8) @(posedge mclk);
        rd(TCC_ADDR_CAP_LO, d);
        chk(d, cap[7:0]);
        // high byte read holds transfers until low byte read
        rd(TCC_ADDR_CAP_HI, d);
        pin.drive(1'b1);
        repeat (8) @(posedge mclk);
        rd(TCC_ADDR_CAP_LO, d);
        chk(d, cap[7:0]);
        // low byte read alone never blocks; status then low read clears the flag
        pin.drive(1'b0);
        pin.drive(1'b1);
        repeat (8) @(posedge mclk);
        rd(TCC_ADDR_CAP_LO, lo0);
        chk((lo0 === cap[7:0]) ? 8'h01 : 8'h00, 8'h00);
        rd(TCC_ADDR_CAP_HI, d);
        rd(TCC_ADDR_CAP_LO, lo0);
        rd(TCC_ADDR_FLAGS, d);
        rd(TCC_ADDR_CAP_LO, d);
        rd(TCC_ADDR_FLAGS, d);
        chk(d & 8'h80, 8'h00);
        // stop mode freezes the counter
        rd16(TCC_ADDR_ALT_HI, TCC_ADDR_ALT_LO, c0);
        @(posedge mclk);
        #1 stop_mode = 1'b1;
        repeat (40) @(posedge mclk);
        #1 stop_mode = 1'b0;
        rd16(TCC_ADDR_ALT_HI, TCC_ADDR_ALT_LO, c1);
        c1 = c1 - c0;
        chk((c1 <= 16'h3) ? 8'h01 : 8'h00, 8'h01);
        // clock enable low freezes the counter as well
        rd16(TCC_ADDR_ALT_HI, TCC_ADDR_ALT_LO, c0);
        @(posedge mclk);
        #1 clk_en = 1'b0;
        repeat (40) @(posedge mclk);
        #1 clk_en = 1'b1;
        rd16(TCC_ADDR_ALT_HI, TCC_ADDR_ALT_LO, c1);
        c1 = c1 - c0;
        chk((c1 <= 16'h3) ? 8'h01 : 8'h00, 8'h01);
        // falling edge capture with the capture interrupt enabled
        wr(TCC_ADDR_CTRL, 8'h80);
        rd16(TCC_ADDR_ALT_HI, TCC_ADDR_ALT_LO, c0);
        pin.drive(1'b0);
        repeat (4) @(posedge mclk);
        #1 chk({7'h0, timer_irq}, 8'h01);
        rd16(TCC_ADDR_CAP_HI, TCC_ADDR_CAP_LO, cap);
        c1 = cap - c0;
        chk((c1 >= 16'h1 && c1 <= 16'h3) ? 8'h01 : 8'h00, 8'h01);
        wr(TCC_ADDR_CTRL, 8'h02);
        // second reset mid-run; capture flag, capture and edge select survive
        @(posedge mclk);
        #1 arst_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1 arst_n = 1'b1;
        chk({7'h0, compare_out_pin}, 8'h00);
        rd(TCC_ADDR_FLAGS, d);
        chk(d & 8'ha0, 8'h80);
        rd(TCC_ADDR_CTRL, d);
        chk(d, 8'h02);
        rd16(TCC_ADDR_CAP_HI, TCC_ADDR_CAP_LO, c0);
        chk(c0[15:8], cap[15:8]);
        chk(c0[7:0], cap[7:0]);
        // wrap not cleared by a count low read without a prior status read
        repeat (20) @(posedge mclk);
        rd(TCC_ADDR_CNT_LO, d);
        rd(TCC_ADDR_FLAGS, d);
        chk(d & 8'h20, 8'h20);
        rd(TCC_ADDR_CNT_LO, d);
        rd(TCC_ADDR_FLAGS, d);
        chk(d & 8'h20, 8'h00);
        final_report;
    end
endmodule

// ==== tb/tcc_pin_model.sv ====
// model of the signal source on the capture input pin
`timescale 1ns/1ps
module tcc_pin_model (
    input wire logic mclk,
    output logic capture_in
);
    // pin idles low until a transition is asked for
    initial begin
        capture_in = 1'b0;
    end

    // move the pin to a new level just after a clock edge
    task automatic drive(input logic level);
        @(posedge mclk);
        #1 capture_in = level;
    endtask
endmodule
